// ===== rtl/neclr_regs.sv
// nand ecc error locator: per-sector result registers on a plain register port
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module neclr_regs (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire neclr_pkg::neclr_bus_t  bus,
  input  wire logic                   page_start,
  input  wire neclr_pkg::neclr_report_t report,
  output logic [neclr_pkg::DATA_W-1:0] rd_data
);

  //////////////////////////////////////////////////////////////////////////////
  // control register

  neclr_pkg::neclr_mode_t mode;
  neclr_pkg::neclr_mode_t next_mode;

  logic ctrl_hit;
  logic multi_hit;
  logic single_hit;
  logic result_hit;
  logic [neclr_pkg::SECT_IDX_W-1:0] rd_idx;

  always_comb begin
    ctrl_hit   = (bus.addr == neclr_pkg::CTRL_ADDR);
    multi_hit  = (bus.addr == neclr_pkg::MULTI_ADDR);
    single_hit = (bus.addr == neclr_pkg::SINGLE_ADDR);
    result_hit = (bus.addr[neclr_pkg::ADDR_W-1:6] == neclr_pkg::RESULT_BASE[neclr_pkg::ADDR_W-1:6])
                 && (bus.addr[1:0] == 2'h0);
    rd_idx     = bus.addr[5:2];
  end

  always_comb begin
    next_mode = mode;
    if (bus.wr && ctrl_hit) begin
      next_mode = neclr_pkg::neclr_mode_t'(bus.wdata[neclr_pkg::CTRL_MODE_BIT]);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= neclr_pkg::neclr_mode_t'(neclr_pkg::CTRL_MODE_RST);
    end else begin
      mode <= next_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // target sector of an incoming report

  logic [neclr_pkg::SECT_IDX_W-1:0] tgt_sect;
  logic [neclr_pkg::WORD_W-1:0]     tgt_word;

  always_comb begin
    tgt_sect = report.sector;
    tgt_word = neclr_pkg::WORD_RST;
    if (report.single_err) begin
      if (mode == neclr_pkg::NECLR_MODE_256) begin
        // byte 256n..256n+255 lands in entry n
        tgt_sect = report.err_page_byte[neclr_pkg::PAGE_BYTE_W-1:neclr_pkg::SECT_LSB_256];
        tgt_word = {1'b0, report.err_page_byte[neclr_pkg::SECT_LSB_256-1:0]};
      end else begin
        // top 512-byte slices 3072-3583 and 3584-4095 reach entries 6 and 7
        tgt_sect = {1'b0,
          report.err_page_byte[neclr_pkg::PAGE_BYTE_W-1:neclr_pkg::SECT_LSB_512]};
        tgt_word = report.err_page_byte[neclr_pkg::SECT_LSB_512-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-sector storage

  neclr_pkg::neclr_entry_t entry      [neclr_pkg::NUM_SECT];
  neclr_pkg::neclr_entry_t next_entry [neclr_pkg::NUM_SECT];
  logic [neclr_pkg::NUM_SECT-1:0] multi_flag;
  logic [neclr_pkg::NUM_SECT-1:0] next_multi_flag;
  logic [neclr_pkg::NUM_SECT-1:0] single_flag;
  logic [neclr_pkg::NUM_SECT-1:0] next_single_flag;

  genvar g;
  generate
    for (g = 0; g < neclr_pkg::NUM_SECT; g++) begin : g_sect
      logic load;

      always_comb begin
        load                = report.valid && (tgt_sect == neclr_pkg::SECT_IDX_W'(g));
        next_entry[g]       = entry[g];
        next_multi_flag[g]  = multi_flag[g];
        next_single_flag[g] = single_flag[g];
        // a new page clears flags; a report in the same cycle still wins
        if (page_start) begin
          next_multi_flag[g]  = 1'b0;
          next_single_flag[g] = 1'b0;
        end
        if (load) begin
          next_entry[g].sector_parity_word = report.sector_parity_word;
          if (report.single_err && !report.multi_err) begin
            next_entry[g].error_byte_index = tgt_word;
            next_entry[g].error_bit_offset = report.error_bit_offset;
            next_single_flag[g]            = 1'b1;
          end else if (report.multi_err) begin
            // location fields left as they were: reader must not trust them
            next_multi_flag[g] = 1'b1;
          end else begin
            next_entry[g].error_byte_index = neclr_pkg::WORD_RST;
            next_entry[g].error_bit_offset = neclr_pkg::BIT_RST;
          end
        end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          entry[g]       <= '{neclr_pkg::PARITY_RST, neclr_pkg::WORD_RST,
                              neclr_pkg::BIT_RST};
          multi_flag[g]  <= 1'b0;
          single_flag[g] <= 1'b0;
        end else begin
          entry[g]       <= next_entry[g];
          multi_flag[g]  <= next_multi_flag[g];
          single_flag[g] <= next_single_flag[g];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read path; writes to result words are dropped

  logic [neclr_pkg::DATA_W-1:0] next_rd_data;
  neclr_pkg::neclr_entry_t      sel;

  always_comb begin
    sel          = entry[rd_idx];
    next_rd_data = neclr_pkg::RD_DATA_RST;
    if (bus.rd) begin
      if (ctrl_hit) begin
        next_rd_data[neclr_pkg::CTRL_MODE_BIT] = mode;
      end else if (multi_hit) begin
        next_rd_data[neclr_pkg::NUM_SECT-1:0] = multi_flag;
      end else if (single_hit) begin
        next_rd_data[neclr_pkg::NUM_SECT-1:0] = single_flag;
      end else if (result_hit) begin
        if (mode == neclr_pkg::NECLR_MODE_256) begin
          // bits 23 and 11 stay zero in this layout
          next_rd_data[neclr_pkg::PARITY_MSB_256:neclr_pkg::PARITY_LSB] =
            sel.sector_parity_word[neclr_pkg::PARITY_MSB_256-neclr_pkg::PARITY_LSB:0];
          next_rd_data[neclr_pkg::WORD_MSB_256:neclr_pkg::WORD_LSB] =
            sel.error_byte_index[neclr_pkg::WORD_MSB_256-neclr_pkg::WORD_LSB:0];
          next_rd_data[neclr_pkg::WORD_LSB-1:neclr_pkg::BIT_LSB] =
            sel.error_bit_offset;
        end else if (rd_idx < neclr_pkg::SECT_IDX_W'(neclr_pkg::NUM_SECT_512)) begin
          next_rd_data[neclr_pkg::PARITY_LSB+neclr_pkg::PARITY_W-1:neclr_pkg::PARITY_LSB] =
            sel.sector_parity_word;
          next_rd_data[neclr_pkg::WORD_LSB+neclr_pkg::WORD_W-1:neclr_pkg::WORD_LSB] =
            sel.error_byte_index;
          next_rd_data[neclr_pkg::WORD_LSB-1:neclr_pkg::BIT_LSB] = sel.error_bit_offset;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= neclr_pkg::RD_DATA_RST;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

`default_nettype wire

// ===== shared/neclr_pkg.sv
// package: constants and carrier types of the nand ecc error locator registers
package neclr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PAGE_BYTE_W = 12;
  localparam int SECT_IDX_W = 4;
  localparam int NUM_SECT = 16;
  localparam int NUM_SECT_512 = 8;
  localparam int PARITY_W = 12;
  localparam int WORD_W = 9;
  localparam int BIT_W = 3;

  // byte addresses of the register words
  localparam logic [ADDR_W-1:0] RESULT_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h40;
  localparam logic [ADDR_W-1:0] MULTI_ADDR = 8'h44;
  localparam logic [ADDR_W-1:0] SINGLE_ADDR = 8'h48;

  // result word layout
  localparam int BIT_LSB = 0;
  localparam int WORD_LSB = 3;
  localparam int PARITY_LSB = 12;
  localparam int WORD_MSB_256 = 10;
  localparam int PARITY_MSB_256 = 22;

  // page byte address slices for sector selection
  localparam int SECT_LSB_256 = 8;
  localparam int SECT_LSB_512 = 9;

  // control register fields
  localparam int CTRL_MODE_BIT = 0;

  // values after reset
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam logic [DATA_W-1:0] RD_DATA_RST = 32'h0000_0000;
  localparam logic [PARITY_W-1:0] PARITY_RST = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RST = 9'h000;
  localparam logic [BIT_W-1:0] BIT_RST = 3'h0;

  // sector code size: one code per 512 bytes or per 256 bytes
  typedef enum logic {
    NECLR_MODE_512 = 1'b0,
    NECLR_MODE_256 = 1'b1
  } neclr_mode_t;

  // one sector result as delivered by the parity engine at page read end
  typedef struct packed {
    logic                   valid;
    logic [SECT_IDX_W-1:0]  sector;
    logic [PARITY_W-1:0]    sector_parity_word;
    logic                   single_err;
    logic                   multi_err;
    logic [PAGE_BYTE_W-1:0] err_page_byte;
    logic [BIT_W-1:0]       error_bit_offset;
  } neclr_report_t;

  // register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } neclr_bus_t;

  // stored per-sector entry
  typedef struct packed {
    logic [PARITY_W-1:0] sector_parity_word;
    logic [WORD_W-1:0]   error_byte_index;
    logic [BIT_W-1:0]    error_bit_offset;
  } neclr_entry_t;

endpackage

// ===== sim/neclr_engine_model.sv
// model of the parity engine: one sector report per call
`timescale 1ns/1ns
`default_nettype none
module neclr_engine_model (
  input  wire logic                     clk,
  output var  neclr_pkg::neclr_report_t report
);
  initial report = '0;
  // fields are scrambled once valid drops, so a stale value never passes
  task automatic send(input neclr_pkg::neclr_report_t r);
    neclr_pkg::neclr_report_t q;
    q = ~r;
    q.valid = 1'b0;
    report <= r;
    @(posedge clk);
    report <= q;
  endtask
endmodule
`default_nettype wire

// ===== sim/neclr_regs_sva.sv
// checker: read timing and result word layout of the sector results
`timescale 1ns/1ns
`default_nettype none
module neclr_regs_sva (
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire neclr_pkg::neclr_bus_t        bus,
  input wire logic                         page_start,
  input wire neclr_pkg::neclr_report_t     report,
  input wire logic [neclr_pkg::DATA_W-1:0] rd_data
);
  neclr_pkg::neclr_report_t lr;
  logic                     m256;
  // shadow of mode and last report; a mode write beside a report is not modelled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lr <= '0;
      m256 <= 1'b0;
    end else begin
      lr <= report;
      if (bus.wr && bus.addr == 8'h40) m256 <= bus.wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_single;
    lr.valid && lr.single_err && bus.rd;
  endsequence
  sequence s_hit_256;
    s_rd_single ##0 (m256 && bus.addr == {2'b00, lr.err_page_byte[11:8], 2'b00});
  endsequence
  sequence s_hit_512;
    s_rd_single ##0 (!m256 && bus.addr == {3'b000, lr.err_page_byte[11:9], 2'b00});
  endsequence
  a_rd_idle_zero: assert property (!bus.rd |=> rd_data == '0)
    else $error("read data not zero outside read answer");
  a_bit_offset: assert property (s_hit_256 |=> rd_data[2:0] == $past(lr.error_bit_offset))
    else $error("bit offset field wrong");
  a_byte_index: assert property (s_hit_256 |=> rd_data[10:3] == $past(lr.err_page_byte[7:0]))
    else $error("byte index field wrong");
  a_sector_parity: assert property (s_hit_256 |=>
    rd_data[22:12] == $past(lr.sector_parity_word[10:0])) else $error("sector parity wrong");
  a_large_sector: assert property (s_hit_512 |=> rd_data[11:0] ==
    {$past(lr.err_page_byte[8:0]), $past(lr.error_bit_offset)}) else $error("512 entry wrong");
  a_pad_zero: assert property (bus.rd && m256 && bus.addr < 8'h40 |=>
    rd_data[31:23] == 9'h0 && !rd_data[11]) else $error("pad bits not zero");
  a_multi_parity: assert property (lr.valid && lr.multi_err && m256 && bus.rd &&
    bus.addr == {2'b00, lr.sector, 2'b00} |=>
    rd_data[22:12] == $past(lr.sector_parity_word[10:0])) else $error("multi parity wrong");
  a_upper_empty: assert property (bus.rd && !m256 && bus.addr[7:5] == 3'b001 |=>
    rd_data == '0) else $error("absent 512 result not zero");
endmodule
bind neclr_regs neclr_regs_sva i_neclr_regs_sva (.clk(clk), .sys_rst(sys_rst), .bus(bus),
  .page_start(page_start), .report(report), .rd_data(rd_data));
`default_nettype wire

// ===== sim/neclr_regs_tb.sv
// testbench: random sector reports and result reads against a model
`timescale 1ns/1ns
`default_nettype none
module neclr_regs_tb;
  logic                     clk;
  logic                     sys_rst;
  logic                     page_start;
  neclr_pkg::neclr_bus_t    bus;
  neclr_pkg::neclr_report_t report;
  logic [31:0]              rd_data;
  neclr_pkg::neclr_entry_t  me [16];
  logic                     mm;
  logic [15:0]              mf;
  logic [15:0]              sf;
  int                       n_fail;
  int                       cmp_count;
  int                       seed;
  neclr_regs i_neclr_regs (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .page_start(page_start), .report(report), .rd_data(rd_data));
  neclr_engine_model i_neclr_engine_model (.clk(clk), .report(report));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] expv(input int s);
    if (mm) return {9'h0, me[s].sector_parity_word[10:0], 1'b0, me[s].error_byte_index[7:0],
      me[s].error_bit_offset};
    return (s < 8) ? {8'h0, me[s]} : 32'h0;
  endfunction
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 cmp_count++;
    if (rd_data !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, rd_data, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask
  // reports go straight into a read of the sector they hit
  task automatic put(input neclr_pkg::neclr_report_t r, input logic ps);
    int s;
    s = !r.single_err ? r.sector : mm ? r.err_page_byte[11:8] : r.err_page_byte[11:9];
    me[s].sector_parity_word = r.sector_parity_word;
    if (r.single_err) me[s].error_byte_index = mm ? {1'b0, r.err_page_byte[7:0]}
                                                  : r.err_page_byte[8:0];
    if (r.single_err) me[s].error_bit_offset = r.error_bit_offset;
    if (!r.single_err && !r.multi_err) me[s][11:0] = 12'h0;
    // page start clears the flag words, a report in the same cycle still sets its flag
    if (ps) begin
      mf = '0;
      sf = '0;
    end
    if (r.single_err) sf[s] = 1'b1;
    else if (r.multi_err) mf[s] = 1'b1;
    page_start <= ps;
    i_neclr_engine_model.send(r);
    page_start <= 1'b0;
    #1 rd(8'(s * 4), expv(s));
  endtask
  task automatic phase(input logic m);
    neclr_pkg::neclr_report_t r;
    logic [63:0] w;
    wr(8'h40, {31'h0, m});
    mm = m;
    rd(8'h40, {31'h0, m});
    for (int i = 0; i < 260; i++) begin
      w = {$random(seed), $random(seed)};
      r = w[33:0];
      r.valid = 1'b1;
      r.multi_err &= !r.single_err;
      if (i < 16) r = {1'b1, 4'(i), w[11:0], 17'h0};
      if (!m) r.sector[3] = 1'b0;
      put(r, w[48]);
      wr({2'b00, w[37:34], 2'b00}, w[63:32]);
      rd({2'b00, w[47:44], 2'b00}, expv(w[47:44]));
      rd(8'h44, {16'h0, mf});
      rd(8'h48, {16'h0, sf});
    end
    // end of page: software reads back every result word and checks it
    for (int k = 0; k < 16; k++) rd(8'(k * 4), expv(k));
  endtask
  task automatic final_report;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    seed = 32'h3720_468c;
    n_fail = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    page_start = 1'b0;
    bus = '0;
    mm = 1'b0;
    mf = '0;
    sf = '0;
    for (int i = 0; i < 16; i++) me[i] = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 rd(8'h00, 32'h0);
    rd(8'hfc, 32'h0);
    phase(1'b0);
    phase(1'b1);
    // reset in mid-run: mode back to 512, results and flags cleared
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1 rd(8'h40, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h48, 32'h0);
    rd(8'hfc, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
